/* File: src/bop_regs.sv */
// bus options quadlet register bank with apb slave
// What this block does
// - bits 31..27 are writable capability flags irmc, cmc, isc, bmc, pmc
// - bit 27 one means power management supported, zero means not
// - reserved bits 26..24, 11..8 and 5..3 always read zero
// - bits 23..16 hold writable cycle master clock accuracy in ppm
// - bits 15..12 size code; payload limit is 2^(code+1), at least 512
// - size code resets to the 2048 byte value; soft reset keeps it
// - oversize incoming block write may be answered with a type error
// - bits 7..6 generation counter, bumped when rom changed since bus reset
// - bits 2..0 read only and always return 010
`timescale 1ns/1ps
module bop_regs (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link events
   input wire logic bus_reset,
   input wire logic rom_edit,
   input wire logic soft_rst,
   // incoming block write requests
   input wire logic blk_wr_valid,
   input wire logic [15:0] blk_wr_len,
   // link side results
   output logic [31:0] bus_opts,
   output logic bus_link_on,
   output logic ack_type_err
);
   bop_chk_if chk_if ();

   // stored state
   bop_pkg::bop_apb_st_t st;
   bop_pkg::bop_apb_st_t next_st;
   logic [4:0] caps;
   logic [4:0] next_caps;
   logic [7:0] acc;
   logic [7:0] next_acc;
   logic [3:0] rec;
   logic [3:0] next_rec;
   logic [1:0] gen;
   logic [1:0] next_gen;
   logic pend;
   logic next_pend;
   logic link_on;
   logic next_link_on;
   logic [7:0] ovr_cnt;
   logic [7:0] next_ovr_cnt;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [31:0] next_bus_opts;

   // decode helpers
   logic setup;
   logic commit;
   logic wr_opts;
   logic wr_ctrl;
   logic [31:0] wr_opts_val;
   logic [31:0] wr_ctrl_val;
   logic srst;

   // assemble the readable quadlet; reserved bits stay zero
   function automatic logic [31:0] opts_word(input logic [4:0] c, input logic [7:0] a,
                                             input logic [3:0] r, input logic [1:0] g);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[bop_pkg::BOP_CAP_HI:bop_pkg::BOP_CAP_LO] = c;
      w[bop_pkg::BOP_ACC_HI:bop_pkg::BOP_ACC_LO] = a;
      w[bop_pkg::BOP_REC_HI:bop_pkg::BOP_REC_LO] = r;
      w[bop_pkg::BOP_GEN_HI:bop_pkg::BOP_GEN_LO] = g;
      w[bop_pkg::BOP_SPD_HI:bop_pkg::BOP_SPD_LO] = bop_pkg::BOP_SPD_VAL;
      opts_word = w;
   endfunction

   // byte lane merge of a write onto the current word
   function automatic logic [31:0] lane_merge(input logic [31:0] cur, input logic [31:0] wd,
                                              input logic [3:0] be);
      logic [31:0] m;
      m = cur;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      lane_merge = m;
   endfunction

   // control word seen by software
   function automatic logic [31:0] ctrl_word(input logic lk);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[bop_pkg::BOP_CTRL_LINK_BIT] = lk;
      ctrl_word = w;
   endfunction

   // status word: pending rom edit, link state, oversize count
   function automatic logic [31:0] stat_word(input logic p, input logic lk,
                                             input logic [7:0] n);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[bop_pkg::BOP_STAT_PEND_BIT] = p;
      w[bop_pkg::BOP_STAT_LINK_BIT] = lk;
      w[bop_pkg::BOP_STAT_CNT_HI:bop_pkg::BOP_STAT_CNT_LO] = n;
      stat_word = w;
   endfunction

   // shared decode of the three word addresses
   function automatic logic addr_mapped(input logic [11:0] a);
      logic hit;
      case (a)
         bop_pkg::BOP_OPTS_OFS: hit = 1'b1;
         bop_pkg::BOP_CTRL_OFS: hit = 1'b1;
         bop_pkg::BOP_STAT_OFS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      addr_mapped = hit;
   endfunction

   // apb sequencing: zero wait states, ready in the first access cycle
   always_comb begin
      setup = psel && !penable;
      commit = (st == bop_pkg::BOP_ST_ACC) && psel && penable && pready;
      next_st = st;
      next_pready = 1'b0;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      case (st)
         bop_pkg::BOP_ST_IDLE: begin
            if (setup) begin
               next_st = bop_pkg::BOP_ST_ACC;
               next_pready = 1'b1;
               next_prdata = 32'h0000_0000;
               if (!pwrite) begin
                  case (paddr)
                     bop_pkg::BOP_OPTS_OFS: next_prdata = opts_word(caps, acc, rec, gen);
                     bop_pkg::BOP_CTRL_OFS: next_prdata = ctrl_word(link_on);
                     bop_pkg::BOP_STAT_OFS: next_prdata = stat_word(pend, link_on, ovr_cnt);
                     default: next_prdata = 32'h0000_0000;
                  endcase
               end
               // unmapped addresses answer with an error, data zero
               next_pslverr = !addr_mapped(paddr);
            end
         end
         bop_pkg::BOP_ST_ACC: begin
            if (commit) begin
               next_st = bop_pkg::BOP_ST_IDLE;
            end else if (!psel) begin
               // an abandoned transfer must not leave ready stuck high
               next_st = bop_pkg::BOP_ST_IDLE;
            end else begin
               next_pready = pready;
               next_pslverr = pslverr;
            end
         end
         default: begin
            next_st = bop_pkg::BOP_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st <= bop_pkg::BOP_ST_IDLE;
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         st <= next_st;
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // register contents
   always_comb begin
      wr_opts = commit && pwrite && (paddr == bop_pkg::BOP_OPTS_OFS);
      wr_ctrl = commit && pwrite && (paddr == bop_pkg::BOP_CTRL_OFS);
      // only writable fields are taken from the merged word
      wr_opts_val = lane_merge(opts_word(caps, acc, rec, gen), pwdata, pstrb);
      wr_ctrl_val = lane_merge(ctrl_word(link_on), pwdata, pstrb);
      srst = soft_rst || (wr_ctrl && wr_ctrl_val[bop_pkg::BOP_CTRL_SRST_BIT]);
      next_caps = caps;
      next_acc = acc;
      next_rec = rec;
      next_gen = gen;
      next_pend = pend;
      next_link_on = link_on;
      next_ovr_cnt = ovr_cnt;
      if (wr_opts) begin
         next_caps = wr_opts_val[bop_pkg::BOP_CAP_HI:bop_pkg::BOP_CAP_LO];
         next_acc = wr_opts_val[bop_pkg::BOP_ACC_HI:bop_pkg::BOP_ACC_LO];
         next_rec = wr_opts_val[bop_pkg::BOP_REC_HI:bop_pkg::BOP_REC_LO];
         next_gen = wr_opts_val[bop_pkg::BOP_GEN_HI:bop_pkg::BOP_GEN_LO];
      end
      if (wr_ctrl) begin
         next_link_on = wr_ctrl_val[bop_pkg::BOP_CTRL_LINK_BIT];
      end
      // a bus reset consumes a pending edit and bumps the generation
      if (bus_reset) begin
         if (pend) begin
            next_gen = gen + bop_pkg::BOP_GEN_ONE;
         end
         next_pend = 1'b0;
      end
      // an edit in the bus reset cycle counts toward the next one
      if (rom_edit) begin
         next_pend = 1'b1;
      end
      if (chk_if.reject && (ovr_cnt != bop_pkg::BOP_CNT_MAX)) begin
         next_ovr_cnt = ovr_cnt + bop_pkg::BOP_CNT_ONE;
      end
      // soft reset clears everything but the size code
      if (srst) begin
         next_caps = bop_pkg::BOP_CAP_RST;
         next_acc = bop_pkg::BOP_ACC_RST;
         next_gen = bop_pkg::BOP_GEN_RST;
         next_pend = 1'b0;
         next_link_on = 1'b0;
         next_ovr_cnt = 8'h00;
         next_rec = rec;
      end
      next_bus_opts = opts_word(next_caps, next_acc, next_rec, next_gen);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         caps <= bop_pkg::BOP_CAP_RST;
         acc <= bop_pkg::BOP_ACC_RST;
         rec <= bop_pkg::BOP_REC_RST;
         gen <= bop_pkg::BOP_GEN_RST;
         pend <= 1'b0;
         link_on <= 1'b0;
         ovr_cnt <= 8'h00;
         bus_opts <= {bop_pkg::BOP_CAP_RST, 3'h0, bop_pkg::BOP_ACC_RST,
                      bop_pkg::BOP_REC_RST, 4'h0, bop_pkg::BOP_GEN_RST,
                      3'h0, bop_pkg::BOP_SPD_VAL};
         bus_link_on <= 1'b0;
      end else begin
         caps <= next_caps;
         acc <= next_acc;
         rec <= next_rec;
         gen <= next_gen;
         pend <= next_pend;
         link_on <= next_link_on;
         ovr_cnt <= next_ovr_cnt;
         bus_opts <= next_bus_opts;
         // link enable trusts software to have set valid fields first
         bus_link_on <= next_link_on;
      end
   end

   // request size check runs beside the bank
   assign chk_if.rec_code = rec;
   assign chk_if.req_valid = blk_wr_valid;
   assign chk_if.req_len = blk_wr_len;
   assign ack_type_err = chk_if.reject;

   bop_size_chk u_chk (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .chk(chk_if.chk)
   );
endmodule

/* File: src/bop_pkg.sv */
// constants and types for the bus options quadlet register bank
package bop_pkg;
   // apb geometry
   localparam int BOP_AW = 12;
   localparam int BOP_DW = 32;
   localparam int BOP_LEN_W = 16;
   localparam int BOP_LIM_W = 17;
   // register byte offsets
   localparam logic [11:0] BOP_OPTS_OFS = 12'h020;
   localparam logic [11:0] BOP_CTRL_OFS = 12'h050;
   localparam logic [11:0] BOP_STAT_OFS = 12'h058;
   // bus options field positions
   localparam int BOP_IRMC_BIT = 31;
   localparam int BOP_CMC_BIT = 30;
   localparam int BOP_ISC_BIT = 29;
   localparam int BOP_BMC_BIT = 28;
   localparam int BOP_PMC_BIT = 27;
   localparam int BOP_CAP_HI = 31;
   localparam int BOP_CAP_LO = 27;
   localparam int BOP_ACC_HI = 23;
   localparam int BOP_ACC_LO = 16;
   localparam int BOP_REC_HI = 15;
   localparam int BOP_REC_LO = 12;
   localparam int BOP_GEN_HI = 7;
   localparam int BOP_GEN_LO = 6;
   localparam int BOP_SPD_HI = 2;
   localparam int BOP_SPD_LO = 0;
   // fixed and reset values
   localparam logic [2:0] BOP_SPD_VAL = 3'h2;
   localparam logic [3:0] BOP_REC_RST = 4'hA;
   localparam logic [3:0] BOP_REC_MIN = 4'h8;
   localparam logic [4:0] BOP_CAP_RST = 5'h00;
   localparam logic [7:0] BOP_ACC_RST = 8'h00;
   localparam logic [1:0] BOP_GEN_RST = 2'h0;
   localparam logic [1:0] BOP_GEN_ONE = 2'h1;
   // control register fields
   localparam int BOP_CTRL_LINK_BIT = 17;
   localparam int BOP_CTRL_SRST_BIT = 16;
   // status register fields
   localparam int BOP_STAT_PEND_BIT = 0;
   localparam int BOP_STAT_LINK_BIT = 1;
   localparam int BOP_STAT_CNT_HI = 15;
   localparam int BOP_STAT_CNT_LO = 8;
   localparam logic [7:0] BOP_CNT_ONE = 8'h01;
   localparam logic [7:0] BOP_CNT_MAX = 8'hFF;
   // apb slave states, one-hot
   typedef enum logic [1:0] {
      BOP_ST_IDLE = 2'b01,
      BOP_ST_ACC = 2'b10
   } bop_apb_st_t;
endpackage

/* File: src/bop_chk_if.sv */
// carrier between the register bank and the request size checker
`timescale 1ns/1ps
interface bop_chk_if;
   logic [3:0] rec_code;
   logic req_valid;
   logic [15:0] req_len;
   logic reject;
   modport bank (output rec_code, output req_valid, output req_len, input reject);
   modport chk (input rec_code, input req_valid, input req_len, output reject);
endinterface

/* File: src/bop_size_chk.sv */
// block write payload length check against the request size limit
`timescale 1ns/1ps
module bop_size_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // checker side of the carrier
   bop_chk_if.chk chk
);
   logic reject;
   logic next_reject;
   logic [3:0] code_eff;

   // limit in bytes is two to the power code plus one
   function automatic logic [bop_pkg::BOP_LIM_W-1:0] rec_bytes(input logic [3:0] code);
      logic [bop_pkg::BOP_LIM_W-1:0] one;
      one = bop_pkg::BOP_LIM_W'(1);
      rec_bytes = one << (5'(code) + 5'd1);
   endfunction

   always_comb begin
      // codes below the floor would undercut 512 bytes, so clamp
      code_eff = (chk.rec_code < bop_pkg::BOP_REC_MIN) ? bop_pkg::BOP_REC_MIN
                                                        : chk.rec_code;
      next_reject = chk.req_valid &&
                    ({1'b0, chk.req_len} > rec_bytes(code_eff));
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reject <= 1'b0;
      end else begin
         reject <= next_reject;
      end
   end

   assign chk.reject = reject;
endmodule

/* File: tb/bop_regs_properties.sv */
// concurrent checks on the bus options register bank ports
`timescale 1ns/1ps
module bop_regs_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link side
   input wire logic bus_reset,
   input wire logic soft_rst,
   input wire logic blk_wr_valid,
   input wire logic [15:0] blk_wr_len,
   input wire logic [31:0] bus_opts,
   input wire logic ack_type_err
);
   logic [3:0] code_eff;
   logic over;
   logic wr_acc;
   logic opt_wr;
   // codes below 8 still mean 512 bytes
   always_comb begin
      code_eff = (bus_opts[15:12] < 4'h8) ? 4'h8 : bus_opts[15:12];
      over = {1'b0, blk_wr_len} > (17'h1 << ({1'b0, code_eff} + 5'h1));
      wr_acc = psel && penable && pready && pwrite;
      opt_wr = wr_acc && paddr == bop_pkg::BOP_OPTS_OFS && !soft_rst && !bus_reset;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   rsvd_zero_a: assert property ((bus_opts & 32'h07000F38) == 32'h0)
      else $error("reserved bits not zero");
   speed_code_a: assert property (bus_opts[2:0] == 3'h2)
      else $error("speed code wrong");
   read_fixed_a: assert property (pready && !pwrite && !pslverr && paddr == 12'h020
      |-> prdata[2:0] == 3'h2 && (prdata & 32'h07000F38) == 32'h0) else $error("bad read");
   ready_next_a: assert property (psel && !penable |=> pready) else $error("no ready");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
   err_data_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("err data");
   size_keep_a: assert property (soft_rst && !wr_acc |=> $stable(bus_opts[15:12]))
      else $error("size code lost");
   gen_hold_a: assert property (!bus_reset && !soft_rst && !wr_acc |=> $stable(bus_opts[7:6]))
      else $error("gen moved");
   caps_write_a: assert property (opt_wr && pstrb[3] |=> bus_opts[31:27] == $past(pwdata[31:27]))
      else $error("caps not written");
   acc_size_write_a: assert property (opt_wr && pstrb[2] && pstrb[1]
      |=> bus_opts[23:16] == $past(pwdata[23:16]) && bus_opts[15:12] == $past(pwdata[15:12]))
      else $error("acc or size not written");
   oversize_a: assert property (blk_wr_valid |=> ack_type_err == $past(over))
      else $error("oversize answer wrong");
   no_spur_a: assert property (!blk_wr_valid |=> !ack_type_err) else $error("spurious error");
   cover property (opt_wr);
   cover property (blk_wr_valid && over);
   cover property (soft_rst);
endmodule
bind bop_regs bop_regs_props u_props (.*);

/* File: tb/test_bus_options_quadlet.sv */
// self-checking bench for the bus options register bank
`timescale 1ns/1ps
module test_bus_options_quadlet;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, bus_opts, rd, m;
   logic [3:0] pstrb = 4'h0;
   logic bus_reset = 1'b0, rom_edit = 1'b0, soft_rst = 1'b0, blk_wr_valid = 1'b0;
   logic [15:0] blk_wr_len = 16'h0000;
   logic pready, pslverr, bus_link_on, ack_type_err, er;
   int failures = 0, checked = 0, r, ovr = 0;
   bop_regs u_bop_regs (.*);
   always #20 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
         input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16)
         failures++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // model keeps only the writable fields, then forces the speed code
   task automatic wopt(input logic [31:0] wd, input logic [3:0] s);
      apb(1'b1, bop_pkg::BOP_OPTS_OFS, wd, s);
      for (int i = 0; i < 4; i++)
         if (s[i])
            m[8*i +: 8] = wd[8*i +: 8];
      m = (m & 32'hF8FFF0C0) | 32'h00000002;
   endtask
   task automatic rchk;
      apb(1'b0, bop_pkg::BOP_OPTS_OFS, 32'h0, 4'h0);
      chk(rd, m);
      chk(bus_opts, m);
   endtask
   task automatic ev(input logic [2:0] k);
      @(posedge clk_sys);
      {soft_rst, rom_edit, bus_reset} <= k;
      @(posedge clk_sys);
      {soft_rst, rom_edit, bus_reset} <= 3'h0;
   endtask
   task automatic blk(input logic [15:0] len);
      int c;
      c = (m[15:12] < 8) ? 8 : m[15:12];
      @(posedge clk_sys);
      blk_wr_valid <= 1'b1;
      blk_wr_len <= len;
      @(posedge clk_sys);
      blk_wr_valid <= 1'b0;
      #1;
      chk({31'h0, ack_type_err}, {31'h0, len > (1 << (c + 1))});
      if (len > (1 << (c + 1)))
         ovr++;
   endtask
   task automatic complete_run;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // well under two hundred cycles are needed, so this limit only trips on a hang
   initial begin
      #400000;
      failures++;
      complete_run;
   end
   initial begin
      r = $urandom(32'h45CA);
      m = 32'h0000A002;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      rchk;
      apb(1'b1, 12'h100, 32'hFFFFFFFF, 4'hF);
      chk({31'h0, er}, 32'h1);
      rchk;
      repeat (6) begin
         wopt($urandom, 4'hF);
         rchk;
      end
      wopt(32'h08000000, 4'h8);
      rchk;
      wopt(32'hFFFFFFFF, 4'h2);
      rchk;
      wopt(32'h000000C0, 4'h1);
      ev(3'h2);
      ev(3'h1);
      m[7:6] = m[7:6] + 2'h1;
      rchk;
      ev(3'h1);
      rchk;
      wopt(32'h00002000, 4'h2);
      blk(16'h0200);
      blk(16'h0201);
      wopt(32'h0000A000, 4'h2);
      blk(16'h0800);
      blk(16'h0801);
      blk(16'($urandom));
      wopt(32'h0000F000, 4'h2);
      blk(16'hFFFF);
      apb(1'b0, bop_pkg::BOP_STAT_OFS, 32'h0, 4'h0);
      chk(rd, {16'h0000, 8'(ovr), 8'h00});
      apb(1'b1, bop_pkg::BOP_CTRL_OFS, 32'h00020000, 4'hF);
      apb(1'b0, bop_pkg::BOP_CTRL_OFS, 32'h0, 4'h0);
      chk(rd, 32'h00020000);
      chk({31'h0, bus_link_on}, 32'h1);
      wopt(32'hFFFFA0FF, 4'hF);
      ev(3'h4);
      m = (m & 32'h0000F000) | 32'h00000002;
      rchk;
      chk({31'h0, bus_link_on}, 32'h0);
      wopt(32'hFFFFFFFF, 4'hF);
      apb(1'b1, bop_pkg::BOP_CTRL_OFS, 32'h00010000, 4'hF);
      m = (m & 32'h0000F000) | 32'h00000002;
      rchk;
      wopt(32'h00002000, 4'h2);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      m = 32'h0000A002;
      rchk;
      complete_run;
   end
endmodule
